//--- logic/psm_pkg.sv
// constants, register map and carrier types for the pin state and function mux
package psm_pkg;

   // ********************************************************************
   // register map (byte addresses, one 32-bit word each)
   // ********************************************************************
   localparam int WB_AW = 8;
   localparam logic [7:0] OFF_TIMER_CTRL = 8'h00;
   localparam logic [7:0] OFF_DMA_MODE = 8'h04;
   localparam logic [7:0] OFF_ASYNC1_CTRL_A = 8'h08;
   localparam logic [7:0] OFF_ASYNC1_STATUS = 8'h0c;
   localparam logic [7:0] OFF_POWER_CTRL = 8'h10;
   localparam logic [7:0] OFF_PIN_STATUS = 8'h14;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [23:0] RD_PAD = 24'h000000;
   localparam logic [31:0] RD_NONE = 32'h00000000;

   // ********************************************************************
   // field positions
   // ********************************************************************
   localparam int TCR_TIMER_CHAN1_OUTPUT_A = 2;
   localparam int TCR_TIMER_CHAN1_OUTPUT_B = 3;
   localparam int DMA_MODE_REG_DMA_REQUEST_0_A = 3;
   localparam int DMA_MODE_REG_DMA_REQUEST_0_B = 5;
   localparam int ASYNC1_CONTROL_A_DMA_TRANSFER_END_0 = 4;
   localparam int ASYNC1_STATUS_REG_CLEAR_TO_SEND_1 = 2;
   localparam int PWR_DOUBLER = 0;
   localparam int PWR_MODE_LSB = 1;
   localparam int PWR_MODE_MSB = 2;
   localparam int A18_BIT = 18;

   localparam logic [19:0] ADDR_ALL_HIGH = 20'hfffff;
   localparam logic [19:0] ADDR_OE_NONE = 20'h00000;
   localparam logic [7:0] DATA_ZERO = 8'h00;

   // ********************************************************************
   // types
   // ********************************************************************
   typedef enum logic [1:0] {PM_RUN, PM_DOZE, PM_STOP, PM_STANDBY} psm_power_mode_type;
   typedef enum logic {BG_IDLE, BG_GRANTED} psm_grant_state_type;

   typedef struct packed {
      logic timer_chan1_output;
      logic dma_request_0;
      logic dma_transfer_end_0;
      logic clear_to_send_1;
   } psm_mux_sel_type;

   typedef struct packed {
      logic [19:0] addr;
      logic [19:0] addr_oe;
      logic [7:0] data;
      logic data_oe;
   } psm_bus_pins_type;

   typedef struct packed {
      logic st;
      logic halt_n;
      logic async_transmit_0;
      logic async_transmit_1;
      logic request_to_send_0_n;
      logic dma_transfer_end_1_n;
      logic async_clock_0;
      logic async_clock_0_oe;
      logic async_clock_1;
      logic async_clock_1_oe;
      logic dma_request_0_n;
      logic async_clock_0_in;
      logic async_clock_1_in;
      logic clear_to_send_1_n;
      logic sync_serial_receive;
      logic bus_grant_n;
      logic core_run;
      logic periph_run;
      logic osc_en;
      logic clk_en;
      logic clk_double;
      logic nmi_allow;
   } psm_ctl_out_type;

   localparam psm_bus_pins_type BUS_RESET = '{addr: ADDR_ALL_HIGH, addr_oe: ADDR_OE_NONE,
                                               data: DATA_ZERO, data_oe: 1'b0};
   localparam psm_ctl_out_type CTL_RESET = '{st: 1'b1, halt_n: 1'b1, async_transmit_0: 1'b1, async_transmit_1: 1'b1,
      request_to_send_0_n: 1'b1, dma_transfer_end_1_n: 1'b1, async_clock_0: 1'b1, async_clock_0_oe: 1'b0, async_clock_1: 1'b1, async_clock_1_oe: 1'b0,
      dma_request_0_n: 1'b1, async_clock_0_in: 1'b1, async_clock_1_in: 1'b1, clear_to_send_1_n: 1'b1, sync_serial_receive: 1'b1,
      bus_grant_n: 1'b1, core_run: 1'b0, periph_run: 1'b0, osc_en: 1'b1, clk_en: 1'b1,
      clk_double: 1'b0, nmi_allow: 1'b0};

endpackage : psm_pkg

//--- logic/psm_pin_mux.sv
// pin state control and shared-pin function selection with a wishbone register slave
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - doubler bit selects internal clock at twice the external clock
// - doze stops the core while peripherals keep running
// - full stop halts core and all peripherals
// - standby stops the oscillator and gates the internal clock
// - address 18 pin carries timer channel 1 output when either timer bit selects
// - async clock 0 pin becomes dma request 0 input when dma mode bits select
// - async clock 1 pin becomes dma transfer end 0 output when its bit selects
// - sync serial receive pin becomes clear to send 1 when status bit selects
// - address floats in reset and bus grant, driven high in doze, except a18 while it carries the timer output
// - data bus floats in reset, bus grant and doze
// - cycle status output high in reset, bus grant and doze
// - halt indicator high in reset and grant, low in doze
// - async transmit outputs high in reset, normal in grant and doze
// - request to send 0 high in reset and doze, normal in grant
// - dma transfer end 1 high in reset and doze, normal in grant
// - async clock 0 pin floats in reset and while it carries dma request 0, bidirectional otherwise
// - after reset the address 18 pin carries the address line
// - bus request honoured at machine cycle end, ahead of nonmaskable interrupt
// - bus grant asserts together with address and data floating and cycle status and halt driven high
module psm_pin_mux (
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [7:0] I_WB_ADR,
   input wire logic [31:0] I_WB_DAT,
   input wire logic [3:0] I_WB_SEL,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   input wire logic [19:0] I_ADDR,
   input wire logic I_ADDR_OE,
   input wire logic [7:0] I_DATA_OUT,
   input wire logic I_DATA_OE,
   input wire logic [7:0] I_DATA_PIN,
   input wire logic I_CYCLE_STATUS,
   input wire logic I_HALT_N,
   input wire logic I_MCYCLE_END,
   input wire logic I_BUS_HOLD_REQUEST_N,
   input wire logic I_TIMER_CHAN1_OUTPUT,
   input wire logic I_ASYNC_TRANSMIT_0,
   input wire logic I_ASYNC_TRANSMIT_1,
   input wire logic I_REQUEST_TO_SEND_0_N,
   input wire logic I_DMA_TRANSFER_END_0_N,
   input wire logic I_DMA_TRANSFER_END_1_N,
   input wire logic I_ASYNC_CLOCK_0_OUT,
   input wire logic I_ASYNC_CLOCK_0_OE,
   input wire logic I_ASYNC_CLOCK_0_PIN,
   input wire logic I_ASYNC_CLOCK_1_OUT,
   input wire logic I_ASYNC_CLOCK_1_OE,
   input wire logic I_ASYNC_CLOCK_1_PIN,
   input wire logic I_SYNC_SERIAL_RECEIVE_PIN,
   output logic [19:0] O_ADDR,
   output logic [19:0] O_ADDR_OE,
   output logic [7:0] O_DATA,
   output logic O_DATA_OE,
   output logic [7:0] O_DATA_IN,
   output logic O_CYCLE_STATUS_OUT,
   output logic O_HALT_N,
   output logic O_ASYNC_TRANSMIT_0,
   output logic O_ASYNC_TRANSMIT_1,
   output logic O_REQUEST_TO_SEND_0_N,
   output logic O_DMA_TRANSFER_END_1_N,
   output logic O_ASYNC_CLOCK_0,
   output logic O_ASYNC_CLOCK_0_OE,
   output logic O_ASYNC_CLOCK_1,
   output logic O_ASYNC_CLOCK_1_OE,
   output logic O_DMA_REQUEST_0_N,
   output logic O_ASYNC_CLOCK_0_IN,
   output logic O_ASYNC_CLOCK_1_IN,
   output logic O_CLEAR_TO_SEND_1_N,
   output logic O_SYNC_SERIAL_RECEIVE,
   output logic O_BUS_GRANT_N,
   output logic O_CORE_RUN,
   output logic O_PERIPH_RUN,
   output logic O_OSC_EN,
   output logic O_CLK_EN,
   output logic O_CLK_DOUBLE,
   output logic O_NMI_ALLOW
);

   // ********************************************************************
   // register slave
   // ********************************************************************
   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
      reg_hit = (adr[7:2] == off[7:2]);
   endfunction : reg_hit

   logic wb_ack_q;
   logic [31:0] wb_dat_q;
   logic [7:0] timer_control_reg_q;
   logic [7:0] dma_mode_reg_q;
   logic [7:0] async1_control_a_q;
   logic [7:0] async1_status_reg_q;
   logic [7:0] power_ctrl_q;
   psm_pkg::psm_grant_state_type grant_state_q;
   psm_pkg::psm_grant_state_type grant_state_d;
   psm_pkg::psm_bus_pins_type bus_q;
   psm_pkg::psm_bus_pins_type bus_d;
   psm_pkg::psm_ctl_out_type ctl_q;
   psm_pkg::psm_ctl_out_type ctl_d;
   logic [7:0] data_in_q;

   wire wb_req = I_WB_CYC & I_WB_STB;
   wire wb_ack_d = wb_req & ~wb_ack_q;
   // a write lands on the edge where the master sees ack, never earlier
   wire wb_wr = wb_req & I_WB_WE & wb_ack_q & I_WB_SEL[0];
   wire wr_tcr = wb_wr & reg_hit(I_WB_ADR, psm_pkg::OFF_TIMER_CTRL);
   wire wr_dma_mode_reg = wb_wr & reg_hit(I_WB_ADR, psm_pkg::OFF_DMA_MODE);
   wire wr_async1_control_a = wb_wr & reg_hit(I_WB_ADR, psm_pkg::OFF_ASYNC1_CTRL_A);
   wire wr_async1_status_reg = wb_wr & reg_hit(I_WB_ADR, psm_pkg::OFF_ASYNC1_STATUS);
   wire wr_pwr = wb_wr & reg_hit(I_WB_ADR, psm_pkg::OFF_POWER_CTRL);

   // ********************************************************************
   // mode and mux decode
   // ********************************************************************
   wire psm_pkg::psm_power_mode_type power_mode =
      psm_pkg::psm_power_mode_type'(power_ctrl_q[psm_pkg::PWR_MODE_MSB:psm_pkg::PWR_MODE_LSB]);
   // stop and standby show the same pin states as doze
   wire sleep = (power_mode != psm_pkg::PM_RUN);
   wire grant = (grant_state_q == psm_pkg::BG_GRANTED);
   wire psm_pkg::psm_mux_sel_type mux_sel = '{
      timer_chan1_output: timer_control_reg_q[psm_pkg::TCR_TIMER_CHAN1_OUTPUT_A] | timer_control_reg_q[psm_pkg::TCR_TIMER_CHAN1_OUTPUT_B],
      dma_request_0: dma_mode_reg_q[psm_pkg::DMA_MODE_REG_DMA_REQUEST_0_A] | dma_mode_reg_q[psm_pkg::DMA_MODE_REG_DMA_REQUEST_0_B],
      dma_transfer_end_0: async1_control_a_q[psm_pkg::ASYNC1_CONTROL_A_DMA_TRANSFER_END_0],
      clear_to_send_1: async1_status_reg_q[psm_pkg::ASYNC1_STATUS_REG_CLEAR_TO_SEND_1]};
   wire [7:0] pin_status = {grant, sleep, power_ctrl_q[psm_pkg::PWR_MODE_MSB:psm_pkg::PWR_MODE_LSB],
                            mux_sel};

   wire [31:0] rd_d =
      reg_hit(I_WB_ADR, psm_pkg::OFF_TIMER_CTRL) ? {psm_pkg::RD_PAD, timer_control_reg_q} :
      reg_hit(I_WB_ADR, psm_pkg::OFF_DMA_MODE) ? {psm_pkg::RD_PAD, dma_mode_reg_q} :
      reg_hit(I_WB_ADR, psm_pkg::OFF_ASYNC1_CTRL_A) ? {psm_pkg::RD_PAD, async1_control_a_q} :
      reg_hit(I_WB_ADR, psm_pkg::OFF_ASYNC1_STATUS) ? {psm_pkg::RD_PAD, async1_status_reg_q} :
      reg_hit(I_WB_ADR, psm_pkg::OFF_POWER_CTRL) ? {psm_pkg::RD_PAD, power_ctrl_q} :
      reg_hit(I_WB_ADR, psm_pkg::OFF_PIN_STATUS) ? {psm_pkg::RD_PAD, pin_status} :
      psm_pkg::RD_NONE;

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= psm_pkg::RD_NONE;
         timer_control_reg_q <= psm_pkg::REG_RESET;
         dma_mode_reg_q <= psm_pkg::REG_RESET;
         async1_control_a_q <= psm_pkg::REG_RESET;
         async1_status_reg_q <= psm_pkg::REG_RESET;
         power_ctrl_q <= psm_pkg::REG_RESET;
      end else begin
         wb_ack_q <= wb_ack_d;
         if (wb_ack_d) begin
            wb_dat_q <= rd_d;
         end
         if (wr_tcr) begin
            timer_control_reg_q <= I_WB_DAT[7:0];
         end
         if (wr_dma_mode_reg) begin
            dma_mode_reg_q <= I_WB_DAT[7:0];
         end
         if (wr_async1_control_a) begin
            async1_control_a_q <= I_WB_DAT[7:0];
         end
         if (wr_async1_status_reg) begin
            async1_status_reg_q <= I_WB_DAT[7:0];
         end
         if (wr_pwr) begin
            power_ctrl_q <= I_WB_DAT[7:0];
         end
      end
   end

   // ********************************************************************
   // bus hold arbitration
   // ********************************************************************
   always_comb begin
      grant_state_d = grant_state_q;
      case (grant_state_q)
         psm_pkg::BG_IDLE: begin
            if (!I_BUS_HOLD_REQUEST_N && I_MCYCLE_END) begin
               grant_state_d = psm_pkg::BG_GRANTED;
            end
         end
         psm_pkg::BG_GRANTED: begin
            // the master has let go of the buses before raising its request
            if (I_BUS_HOLD_REQUEST_N) begin
               grant_state_d = psm_pkg::BG_IDLE;
            end
         end
         default: begin
            grant_state_d = psm_pkg::BG_IDLE;
         end
      endcase
   end

   // ********************************************************************
   // pin state selection
   // ********************************************************************
   always_comb begin
      bus_d.addr = I_ADDR;
      bus_d.addr_oe = {20{I_ADDR_OE}};
      bus_d.data = I_DATA_OUT;
      bus_d.data_oe = I_DATA_OE;
      if (grant) begin
         bus_d.addr_oe = psm_pkg::ADDR_OE_NONE;
         bus_d.data_oe = 1'b0;
      end else if (sleep) begin
         bus_d.addr = psm_pkg::ADDR_ALL_HIGH;
         bus_d.addr_oe = psm_pkg::ADDR_ALL_HIGH;
         bus_d.data_oe = 1'b0;
      end
      // the timer output keeps driving through grant and sleep
      if (mux_sel.timer_chan1_output) begin
         bus_d.addr[psm_pkg::A18_BIT] = I_TIMER_CHAN1_OUTPUT;
         bus_d.addr_oe[psm_pkg::A18_BIT] = 1'b1;
      end
   end

   always_comb begin
      ctl_d.st = (grant | sleep) ? 1'b1 : I_CYCLE_STATUS;
      ctl_d.halt_n = grant ? 1'b1 : (sleep ? 1'b0 : I_HALT_N);
      ctl_d.async_transmit_0 = I_ASYNC_TRANSMIT_0;
      ctl_d.async_transmit_1 = I_ASYNC_TRANSMIT_1;
      ctl_d.request_to_send_0_n = sleep ? 1'b1 : I_REQUEST_TO_SEND_0_N;
      ctl_d.dma_transfer_end_1_n = sleep ? 1'b1 : I_DMA_TRANSFER_END_1_N;
      ctl_d.async_clock_0 = I_ASYNC_CLOCK_0_OUT;
      ctl_d.async_clock_0_oe = mux_sel.dma_request_0 ? 1'b0 : I_ASYNC_CLOCK_0_OE;
      ctl_d.dma_request_0_n = mux_sel.dma_request_0 ? I_ASYNC_CLOCK_0_PIN : 1'b1;
      ctl_d.async_clock_0_in = mux_sel.dma_request_0 ? 1'b1 : I_ASYNC_CLOCK_0_PIN;
      if (mux_sel.dma_transfer_end_0) begin
         ctl_d.async_clock_1 = (grant | sleep) ? 1'b1 : I_DMA_TRANSFER_END_0_N;
         ctl_d.async_clock_1_oe = 1'b1;
         ctl_d.async_clock_1_in = 1'b1;
      end else begin
         ctl_d.async_clock_1 = I_ASYNC_CLOCK_1_OUT;
         ctl_d.async_clock_1_oe = I_ASYNC_CLOCK_1_OE;
         ctl_d.async_clock_1_in = I_ASYNC_CLOCK_1_PIN;
      end
      ctl_d.clear_to_send_1_n = mux_sel.clear_to_send_1 ? I_SYNC_SERIAL_RECEIVE_PIN : 1'b1;
      ctl_d.sync_serial_receive = I_SYNC_SERIAL_RECEIVE_PIN;
      ctl_d.bus_grant_n = ~grant;
      ctl_d.core_run = (power_mode == psm_pkg::PM_RUN) & ~grant;
      ctl_d.periph_run = (power_mode == psm_pkg::PM_RUN) | (power_mode == psm_pkg::PM_DOZE);
      ctl_d.osc_en = (power_mode != psm_pkg::PM_STANDBY);
      ctl_d.clk_en = (power_mode != psm_pkg::PM_STANDBY);
      ctl_d.clk_double = power_ctrl_q[psm_pkg::PWR_DOUBLER];
      // a pending or granted bus hold outranks the nonmaskable interrupt
      ctl_d.nmi_allow = I_BUS_HOLD_REQUEST_N & ~grant;
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         grant_state_q <= psm_pkg::BG_IDLE;
         bus_q <= psm_pkg::BUS_RESET;
         ctl_q <= psm_pkg::CTL_RESET;
         data_in_q <= psm_pkg::DATA_ZERO;
      end else begin
         grant_state_q <= grant_state_d;
         bus_q <= bus_d;
         ctl_q <= ctl_d;
         data_in_q <= I_DATA_PIN;
      end
   end

   // ********************************************************************
   // outputs
   // ********************************************************************
   assign O_WB_ACK = wb_ack_q;
   assign O_WB_DAT = wb_dat_q;
   assign O_ADDR = bus_q.addr;
   assign O_ADDR_OE = bus_q.addr_oe;
   assign O_DATA = bus_q.data;
   assign O_DATA_OE = bus_q.data_oe;
   assign O_DATA_IN = data_in_q;
   assign O_CYCLE_STATUS_OUT = ctl_q.st;
   assign O_HALT_N = ctl_q.halt_n;
   assign O_ASYNC_TRANSMIT_0 = ctl_q.async_transmit_0;
   assign O_ASYNC_TRANSMIT_1 = ctl_q.async_transmit_1;
   assign O_REQUEST_TO_SEND_0_N = ctl_q.request_to_send_0_n;
   assign O_DMA_TRANSFER_END_1_N = ctl_q.dma_transfer_end_1_n;
   assign O_ASYNC_CLOCK_0 = ctl_q.async_clock_0;
   assign O_ASYNC_CLOCK_0_OE = ctl_q.async_clock_0_oe;
   assign O_ASYNC_CLOCK_1 = ctl_q.async_clock_1;
   assign O_ASYNC_CLOCK_1_OE = ctl_q.async_clock_1_oe;
   assign O_DMA_REQUEST_0_N = ctl_q.dma_request_0_n;
   assign O_ASYNC_CLOCK_0_IN = ctl_q.async_clock_0_in;
   assign O_ASYNC_CLOCK_1_IN = ctl_q.async_clock_1_in;
   assign O_CLEAR_TO_SEND_1_N = ctl_q.clear_to_send_1_n;
   assign O_SYNC_SERIAL_RECEIVE = ctl_q.sync_serial_receive;
   assign O_BUS_GRANT_N = ctl_q.bus_grant_n;
   assign O_CORE_RUN = ctl_q.core_run;
   assign O_PERIPH_RUN = ctl_q.periph_run;
   assign O_OSC_EN = ctl_q.osc_en;
   assign O_CLK_EN = ctl_q.clk_en;
   assign O_CLK_DOUBLE = ctl_q.clk_double;
   assign O_NMI_ALLOW = ctl_q.nmi_allow;

   // ********************************************************************
   // assertions
   // ********************************************************************
   default clocking cb @(posedge I_CORE_CLK); endclocking

   property p_addr_float;
      (!I_RESET_N || grant) |=> (O_ADDR_OE[17:0] == 18'h00000);
   endproperty
   a_addr_float: assert property (p_addr_float) else $error("address not floating");

   property p_addr_doze;
      disable iff (!I_RESET_N) (!grant && sleep) |=> (O_ADDR[17:0] == 18'h3ffff)
         && (O_ADDR_OE[17:0] == 18'h3ffff);
   endproperty
   a_addr_doze: assert property (p_addr_doze) else $error("address not high in doze");

   property p_data_float;
      (!I_RESET_N || grant || sleep) |=> !O_DATA_OE;
   endproperty
   a_data_float: assert property (p_data_float) else $error("data bus driven");

   property p_status_high;
      (!I_RESET_N || grant || sleep) |=> O_CYCLE_STATUS_OUT;
   endproperty
   a_status_high: assert property (p_status_high) else $error("cycle status not high");

   property p_halt_doze;
      disable iff (!I_RESET_N) (sleep && !grant) |=> !O_HALT_N;
   endproperty
   a_halt_doze: assert property (p_halt_doze) else $error("halt not low in doze");

   property p_txa_reset;
      !I_RESET_N |=> (O_ASYNC_TRANSMIT_0 && O_ASYNC_TRANSMIT_1 && O_REQUEST_TO_SEND_0_N
         && O_DMA_TRANSFER_END_1_N && !O_ASYNC_CLOCK_0_OE);
   endproperty
   a_txa_reset: assert property (p_txa_reset) else $error("reset pin states wrong");

   property p_rts_grant;
      disable iff (!I_RESET_N) (grant && !sleep) |=> (O_REQUEST_TO_SEND_0_N == $past(I_REQUEST_TO_SEND_0_N))
         && (O_DMA_TRANSFER_END_1_N == $past(I_DMA_TRANSFER_END_1_N));
   endproperty
   a_rts_grant: assert property (p_rts_grant) else $error("modem pins not passed in grant");

   property p_timer_chan1_output;
      disable iff (!I_RESET_N) mux_sel.timer_chan1_output |=> O_ADDR_OE[18] && (O_ADDR[18] == $past(I_TIMER_CHAN1_OUTPUT));
   endproperty
   a_timer_chan1_output: assert property (p_timer_chan1_output) else $error("timer output not on address 18");

   property p_a18_default;
      !I_RESET_N ##1 (I_RESET_N && !wb_wr) |=> !mux_sel.timer_chan1_output;
   endproperty
   a_a18_default: assert property (p_a18_default) else $error("address 18 not default");

   property p_grant;
      disable iff (!I_RESET_N) (!grant && !I_BUS_HOLD_REQUEST_N && I_MCYCLE_END) ##1 I_RESET_N
         |-> grant ##1 (!O_BUS_GRANT_N && (O_ADDR_OE[17:0] == 18'h00000) && !O_DATA_OE);
   endproperty
   a_grant: assert property (p_grant) else $error("bus grant late");

   property p_standby;
      disable iff (!I_RESET_N) (power_mode == psm_pkg::PM_STANDBY) |=> !O_OSC_EN && !O_CLK_EN
         && !O_CORE_RUN && !O_PERIPH_RUN;
   endproperty
   a_standby: assert property (p_standby) else $error("clocks not stopped");

endmodule : psm_pin_mux

`default_nettype wire

//--- dv/psm_ext_master.sv
// external bus master model that borrows the shared address and data bus
`timescale 1ns/10ps
`default_nettype none
module psm_ext_master #(
   parameter int HOLD = 6
) (
   input wire logic clk,
   input wire logic go,
   input wire logic bus_grant_n,
   output logic req_n,
   output logic [7:0] dat,
   output logic dat_oe
);
   initial begin
      req_n = 1'b1;
      dat = 8'h00;
      dat_oe = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            req_n <= 1'b0;
            // sampled mid-cycle so the registered grant has settled
            do @(negedge clk); while (bus_grant_n !== 1'b0);
            @(posedge clk);
            dat_oe <= 1'b1;
            dat <= 8'h5a;
            repeat (HOLD) @(posedge clk);
            dat_oe <= 1'b0;
            dat <= 8'ha5;
            @(posedge clk);
            req_n <= 1'b1;
            while (go) @(posedge clk);
         end
      end
   end
endmodule : psm_ext_master
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the pin state and function mux
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic I_CORE_CLK, I_RESET_N, I_WB_CYC, I_WB_STB, I_WB_WE, O_WB_ACK, I_ADDR_OE, I_DATA_OE;
   logic [7:0] I_WB_ADR, I_DATA_OUT, I_DATA_PIN, O_DATA, O_DATA_IN;
   logic [31:0] I_WB_DAT, O_WB_DAT;
   logic [3:0] I_WB_SEL;
   logic [19:0] I_ADDR, O_ADDR, O_ADDR_OE;
   logic I_CYCLE_STATUS, I_HALT_N, I_MCYCLE_END, I_BUS_HOLD_REQUEST_N, I_TIMER_CHAN1_OUTPUT;
   logic I_ASYNC_TRANSMIT_0, I_ASYNC_TRANSMIT_1, I_REQUEST_TO_SEND_0_N, I_DMA_TRANSFER_END_0_N;
   logic I_DMA_TRANSFER_END_1_N, I_ASYNC_CLOCK_0_OUT, I_ASYNC_CLOCK_0_OE, I_ASYNC_CLOCK_0_PIN;
   logic I_ASYNC_CLOCK_1_OUT, I_ASYNC_CLOCK_1_OE, I_ASYNC_CLOCK_1_PIN, I_SYNC_SERIAL_RECEIVE_PIN;
   logic O_DATA_OE, O_CYCLE_STATUS_OUT, O_HALT_N, O_ASYNC_TRANSMIT_0, O_ASYNC_TRANSMIT_1;
   logic O_REQUEST_TO_SEND_0_N, O_DMA_TRANSFER_END_1_N, O_ASYNC_CLOCK_0, O_ASYNC_CLOCK_0_OE;
   logic O_ASYNC_CLOCK_1, O_ASYNC_CLOCK_1_OE, O_DMA_REQUEST_0_N, O_ASYNC_CLOCK_0_IN;
   logic O_ASYNC_CLOCK_1_IN, O_CLEAR_TO_SEND_1_N, O_SYNC_SERIAL_RECEIVE, O_BUS_GRANT_N;
   logic O_CORE_RUN, O_PERIPH_RUN, O_OSC_EN, O_CLK_EN, O_CLK_DOUBLE, O_NMI_ALLOW;
   logic go, p_oe;
   logic [7:0] p_dat;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   // ******************************************************************
   // design, far-side master and the resolved data pins (pulled up)
   // ******************************************************************
   psm_pin_mux i_dut (.*);
   psm_ext_master i_master (.clk(I_CORE_CLK), .go(go), .bus_grant_n(O_BUS_GRANT_N),
      .req_n(I_BUS_HOLD_REQUEST_N), .dat(p_dat), .dat_oe(p_oe));
   assign I_DATA_PIN = p_oe ? p_dat : (O_DATA_OE ? O_DATA : 8'hff);
   initial begin
      I_CORE_CLK = 1'b0;
      forever #5 I_CORE_CLK = ~I_CORE_CLK;
   end
   always @(posedge I_CORE_CLK) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         results();
      end
   end
   // ******************************************************************
   // helpers
   // ******************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic settle();
      repeat (2) @(posedge I_CORE_CLK);
      @(negedge I_CORE_CLK);
   endtask : settle
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
      @(posedge I_CORE_CLK);
      {I_WB_CYC, I_WB_STB, I_WB_WE, I_WB_ADR, I_WB_DAT, I_WB_SEL} <= {2'b11, we, a, d, s};
      do @(posedge I_CORE_CLK); while (O_WB_ACK !== 1'b1);
      q = O_WB_DAT;
      {I_WB_CYC, I_WB_STB} <= 2'b00;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, 4'h1, q);
      settle();
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h00000000, 4'hf, q);
      chk(q, exp);
   endtask : rd_chk
   task automatic wait_grant(input logic lvl);
      int n;
      n = 0;
      @(negedge I_CORE_CLK);
      while (O_BUS_GRANT_N !== lvl && n < 20) begin
         n++;
         @(negedge I_CORE_CLK);
      end
      chk(O_BUS_GRANT_N, lvl);
   endtask : wait_grant
   // ******************************************************************
   // scenarios
   // ******************************************************************
   task automatic t_reset();
      // inputs sit opposite to the forced levels, so a pass-through shows up
      @(negedge I_CORE_CLK);
      chk(O_ADDR_OE, 20'h00000);
      chk(O_DATA_OE, 1'b0);
      chk({O_CYCLE_STATUS_OUT, O_HALT_N}, 2'b11);
      chk({O_ASYNC_TRANSMIT_0, O_ASYNC_TRANSMIT_1}, 2'b11);
      chk({O_REQUEST_TO_SEND_0_N, O_DMA_TRANSFER_END_1_N}, 2'b11);
      chk(O_ASYNC_CLOCK_0_OE, 1'b0);
   endtask : t_reset
   task automatic t_regs();
      logic [31:0] q;
      rd_chk(psm_pkg::OFF_TIMER_CTRL, 32'h00000000);
      rd_chk(psm_pkg::OFF_DMA_MODE, 32'h00000000);
      wr(psm_pkg::OFF_TIMER_CTRL, 32'h0000000c);
      rd_chk(psm_pkg::OFF_TIMER_CTRL, 32'h0000000c);
      wb(1'b1, psm_pkg::OFF_TIMER_CTRL, 32'h00000000, 4'h0, q);
      rd_chk(psm_pkg::OFF_TIMER_CTRL, 32'h0000000c);
      wr(8'h40, 32'h000000ff);
      rd_chk(8'h40, 32'h00000000);
   endtask : t_regs
   task automatic t_mux();
      wr(psm_pkg::OFF_TIMER_CTRL, 32'h00000004);
      chk({O_ADDR[18], O_ADDR_OE[18]}, 2'b11);
      wr(psm_pkg::OFF_TIMER_CTRL, 32'h00000008);
      chk({O_ADDR[18], O_ADDR_OE[18]}, 2'b11);
      wr(psm_pkg::OFF_TIMER_CTRL, 32'h00000000);
      chk(O_ADDR[18], 1'b0);
      wr(psm_pkg::OFF_DMA_MODE, 32'h00000008);
      chk(O_DMA_REQUEST_0_N, 1'b0);
      wr(psm_pkg::OFF_DMA_MODE, 32'h00000020);
      chk(O_DMA_REQUEST_0_N, 1'b0);
      wr(psm_pkg::OFF_ASYNC1_CTRL_A, 32'h00000010);
      chk({O_ASYNC_CLOCK_1, O_ASYNC_CLOCK_1_OE}, 2'b01);
      wr(psm_pkg::OFF_ASYNC1_STATUS, 32'h00000004);
      chk(O_CLEAR_TO_SEND_1_N, 1'b0);
   endtask : t_mux
   task automatic t_power();
      @(posedge I_CORE_CLK);
      I_HALT_N <= 1'b1;
      // async clock 0 must be back on its clock function to be seen driving
      wr(psm_pkg::OFF_DMA_MODE, 32'h00000000);
      wr(psm_pkg::OFF_POWER_CTRL, 32'(psm_pkg::PM_DOZE) << psm_pkg::PWR_MODE_LSB);
      chk({O_ADDR, O_ADDR_OE}, {psm_pkg::ADDR_ALL_HIGH, 20'hfffff});
      chk(O_DATA_OE, 1'b0);
      chk({O_CYCLE_STATUS_OUT, O_HALT_N}, 2'b10);
      chk(O_ASYNC_TRANSMIT_0, 1'b0);
      chk({O_REQUEST_TO_SEND_0_N, O_DMA_TRANSFER_END_1_N}, 2'b11);
      chk(O_ASYNC_CLOCK_0_OE, 1'b1);
      chk({O_CORE_RUN, O_PERIPH_RUN}, 2'b01);
      wr(psm_pkg::OFF_POWER_CTRL, 32'(psm_pkg::PM_STOP) << psm_pkg::PWR_MODE_LSB);
      chk({O_CORE_RUN, O_PERIPH_RUN}, 2'b00);
      wr(psm_pkg::OFF_POWER_CTRL, 32'(psm_pkg::PM_STANDBY) << psm_pkg::PWR_MODE_LSB);
      chk({O_OSC_EN, O_CLK_EN}, 2'b00);
      wr(psm_pkg::OFF_POWER_CTRL, 32'h00000001);
      chk({O_CLK_DOUBLE, O_CORE_RUN, O_OSC_EN}, 3'b111);
   endtask : t_power
   task automatic t_grant();
      @(posedge I_CORE_CLK);
      go <= 1'b1;
      repeat (4) @(posedge I_CORE_CLK);
      @(negedge I_CORE_CLK);
      chk(O_BUS_GRANT_N, 1'b1);
      @(posedge I_CORE_CLK);
      I_MCYCLE_END <= 1'b1;
      wait_grant(1'b0);
      chk({O_ADDR_OE, O_DATA_OE}, 21'h000000);
      chk({O_CYCLE_STATUS_OUT, O_HALT_N}, 2'b11);
      chk({O_ASYNC_TRANSMIT_0, O_REQUEST_TO_SEND_0_N, O_DMA_TRANSFER_END_1_N}, 3'b000);
      chk(O_NMI_ALLOW, 1'b0);
      settle();
      chk(O_DATA_IN, 8'h5a);
      @(posedge I_CORE_CLK);
      go <= 1'b0;
      wait_grant(1'b1);
      @(negedge I_CORE_CLK);
      chk(O_ADDR_OE, 20'hfffff);
   endtask : t_grant
   task automatic results();
      $display("compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   // ******************************************************************
   // main sequence
   // ******************************************************************
   initial begin
      I_RESET_N = 1'b0;
      go = 1'b0;
      {I_WB_CYC, I_WB_STB, I_WB_WE, I_WB_ADR, I_WB_DAT, I_WB_SEL} = '0;
      {I_ADDR, I_DATA_OUT, I_MCYCLE_END, I_CYCLE_STATUS, I_HALT_N} = '0;
      {I_ADDR_OE, I_DATA_OE, I_TIMER_CHAN1_OUTPUT, I_ASYNC_CLOCK_0_OE} = 4'hf;
      {I_ASYNC_TRANSMIT_0, I_ASYNC_TRANSMIT_1, I_REQUEST_TO_SEND_0_N} = '0;
      {I_DMA_TRANSFER_END_0_N, I_DMA_TRANSFER_END_1_N, I_ASYNC_CLOCK_0_OUT} = '0;
      {I_ASYNC_CLOCK_0_PIN, I_ASYNC_CLOCK_1_OUT, I_ASYNC_CLOCK_1_OE} = '0;
      {I_ASYNC_CLOCK_1_PIN, I_SYNC_SERIAL_RECEIVE_PIN} = '0;
      repeat (12) @(posedge I_CORE_CLK);
      t_reset();
      @(posedge I_CORE_CLK);
      I_RESET_N <= 1'b1;
      t_regs();
      t_mux();
      t_power();
      wr(psm_pkg::OFF_POWER_CTRL, 32'h00000000);
      t_grant();
      results();
   end
endmodule : testbench
`default_nettype wire
